// ---- design/pmev_burst_if.sv ----
// pmev_burst_if: load, tick and state lines between control and timer.
// assumes both ends share i_clock.
`timescale 1ns/1ps
interface pmev_burst_if #(parameter int W = 8);
   logic         load;
   logic [W-1:0] reload;
   logic         tick;
   logic         busy;
   logic         expire;
   modport ctrl  (output load, reload, tick, input busy, expire);
   modport timer (input load, reload, tick, output busy, expire);
endinterface : pmev_burst_if

// ---- design/pmev_burst_timer.sv ----
// pmev_burst_timer: reloadable down counter on the slow tick.
// assumes load and tick are single cycle pulses on i_clock.
`timescale 1ns/1ps
module pmev_burst_timer (
   input  wire logic   i_clock,   // system clock
   input  wire logic   i_arst_n,  // async reset, active low
   pmev_burst_if.timer bus        // load and status lines
);
   localparam int W = $bits(bus.reload);
   logic [W-1:0] count_q;
   logic         expire_q;
   wire          last = bus.tick && (count_q == W'(1));

   // a reload mid-burst restarts the count
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         count_q  <= '0;
         expire_q <= 1'b0;
      end else begin
         expire_q <= last && !bus.load;                 // see [RULE13]
         if (bus.load) begin
            count_q <= bus.reload;                      // see [RULE12]
         end else if (bus.tick && count_q != '0) begin
            count_q <= count_q - W'(1);                 // see [RULE12]
         end
      end
   end

   assign bus.busy   = (count_q != '0);
   assign bus.expire = expire_q;
endmodule : pmev_burst_timer

// ---- design/pmev_pkg.sv ----
// pmev_pkg: constants, register map and types of the pm event block.
// assumes a 100 MHz clock and word wide accesses to the i/o window.
// How it works
// [RULE1] held button past four seconds forces soft off
// [RULE2] pending resume flag wakes right after override
// [RULE3] no power good, no override detection
// [RULE4] override flag hardware set, write one clears
// [RULE5] alarm flag set by gated alarm only
// [RULE6] alarm gate sits at enable bit ten
// [RULE7] route select set sends events to sci
// [RULE8] route select clear sends events to smi
// [RULE9] release and overflow sci ignore route select
// [RULE10] long thermal alert throttles even in stop grant
// [RULE11] thermal release restores previous clock state
// [RULE12] burst event reloads timer, full clock runs
// [RULE13] burst expiry returns to clock control
// [RULE14] two burst timers, fast and slow
// [RULE15] software keeps burst events enabled during bursts
// [RULE16] long intervals counted on free slow timebase
package pmev_pkg;
   // ****************************************************************
   // register map
   // ****************************************************************
   localparam logic [2:0]  PMEV_OFS_STATUS  = 3'h0;
   localparam logic [2:0]  PMEV_OFS_ENABLE  = 3'h2;
   localparam logic [2:0]  PMEV_OFS_CONTROL = 3'h4;
   localparam logic [15:0] PMEV_RST_STATUS  = 16'h0000;
   localparam logic [15:0] PMEV_RST_ENABLE  = 16'h0000;
   localparam logic [15:0] PMEV_RST_CONTROL = 16'h0000;
   // status and enable share bit positions
   localparam int PMEV_BIT_TMROF = 0;
   localparam int PMEV_BIT_RLS   = 5;
   localparam int PMEV_BIT_BTN   = 8;
   localparam int PMEV_BIT_ALARM = 10;
   localparam int PMEV_BIT_OVR   = 11;
   localparam int PMEV_BIT_LID   = 12;
   localparam int PMEV_BIT_THERM = 13;
   localparam int PMEV_BIT_GPI   = 14;
   localparam logic [15:0] PMEV_STATUS_MASK  = 16'h7d21;
   localparam logic [15:0] PMEV_ENABLE_MASK  = 16'h7521;
   localparam int PMEV_CTL_SCI     = 0;
   localparam int PMEV_CTL_OVR_EN  = 1;
   localparam int PMEV_CTL_FAST_EN = 2;
   localparam int PMEV_CTL_SLOW_EN = 3;
   localparam int PMEV_CTL_CLKCTL  = 4;
   localparam logic [15:0] PMEV_CONTROL_MASK = 16'h001f;
   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int PMEV_CLOCK_PERIOD_NS = 10;
   localparam int PMEV_SLOW_TICK_US    = 1000;
   localparam int PMEV_SLOW_DIV_CYCLES =
      PMEV_SLOW_TICK_US * 1000 / PMEV_CLOCK_PERIOD_NS;
   localparam int PMEV_OVERRIDE_TIME_MS = 4000;
   localparam int PMEV_OVR_TICKS =
      PMEV_OVERRIDE_TIME_MS * 1000 / PMEV_SLOW_TICK_US;
   localparam int PMEV_THERM_TIME_MS = 2000;
   localparam int PMEV_THERM_TICKS =
      PMEV_THERM_TIME_MS * 1000 / PMEV_SLOW_TICK_US;
   localparam int PMEV_BURST_W          = 8;
   localparam int PMEV_FAST_BURST_TICKS = 4;
   localparam int PMEV_SLOW_BURST_TICKS = 32;
   typedef enum logic {PMEV_RUN, PMEV_SOFT_OFF} pmev_power_e;
endpackage : pmev_pkg

// ---- design/pmev_top.sv ----
// pmev_top: pm status, enables, control, override, thermal, bursts.
// assumes word accesses at even offsets and pins async to i_clock.
`timescale 1ns/1ps
module pmev_top #(
   parameter int unsigned SLOW_DIV    = pmev_pkg::PMEV_SLOW_DIV_CYCLES,
   parameter int unsigned OVR_TICKS   = pmev_pkg::PMEV_OVR_TICKS,
   parameter int unsigned THERM_TICKS = pmev_pkg::PMEV_THERM_TICKS
) (
   input  wire logic        i_clock,               // 100 MHz clock
   input  wire logic        i_arst_n,              // async reset, low
   input  wire logic        i_io_sel,              // window selected
   input  wire logic        i_io_wr,               // write strobe
   input  wire logic        i_io_rd,               // read strobe
   input  wire logic [2:0]  i_io_addr,             // byte offset
   input  wire logic [15:0] i_io_wdata,            // write data
   output logic      [15:0] o_io_rdata,            // read data
   input  wire logic        i_power_button_n,      // button pin
   input  wire logic        i_lid_input,           // lid pin
   input  wire logic        i_thermal_alert_n,     // thermal pin
   input  wire logic        i_general_input_one_n, // gp input pin
   input  wire logic        i_power_good,          // power good pin
   input  wire logic        i_rtc_irq8,            // rtc alarm level
   input  wire logic        i_firmware_release,    // release pulse
   input  wire logic        i_pm_timer_overflow,   // overflow pulse
   input  wire logic        i_fast_burst_event,    // fast burst pulse
   input  wire logic        i_slow_burst_event,    // slow burst pulse
   output logic             o_sci,                 // sci to host
   output logic             o_smi,                 // smi to host
   output logic             o_soft_off,            // soft off state
   output logic             o_clock_stop_request_n // clock stop, low
);
   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   localparam int NSYNC = 5;
   wire  [NSYNC-1:0] sync2_q, prev_q;
   wire  [NSYNC-1:0] pins = {i_power_good, i_general_input_one_n,
                             i_thermal_alert_n, i_lid_input,
                             i_power_button_n};
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         // flops kept local so that each bit has one process of its own
         logic meta_q, stable_q, last_q;
         always_ff @(posedge i_clock or negedge i_arst_n) begin
            if (!i_arst_n) begin
               meta_q   <= 1'b0;
               stable_q <= 1'b0;
               last_q   <= 1'b0;
            end else begin
               meta_q   <= pins[gi];
               stable_q <= meta_q;
               last_q   <= stable_q;
            end
         end
         assign sync2_q[gi] = stable_q;
         assign prev_q[gi]  = last_q;
      end
   endgenerate
   // reset state of the sync flops reads as "pressed"; masked by the
   // power good gate, which also comes up low
   wire btn_held   = !sync2_q[0];
   wire btn_press  = !sync2_q[0] && prev_q[0];
   wire lid_change = sync2_q[1] ^ prev_q[1];
   wire therm_held = !sync2_q[2];
   wire therm_fall = !sync2_q[2] && prev_q[2];
   wire gpi_fall   = !sync2_q[3] && prev_q[3];
   wire pwr_good   = sync2_q[4];

   // ****************************************************************
   // slow timebase, free running in every state
   // ****************************************************************
   logic [31:0] div_q;
   logic        slow_tick_q;
   logic        phase_q;
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         div_q       <= '0;
         slow_tick_q <= 1'b0;
         phase_q     <= 1'b0;
      end else begin
         slow_tick_q <= (div_q == 32'(SLOW_DIV - 1));      // see [RULE16]
         div_q       <= (div_q == 32'(SLOW_DIV - 1)) ? '0 : div_q + 32'h1;
         if (slow_tick_q) phase_q <= !phase_q;
      end
   end

   // ****************************************************************
   // registers
   // ****************************************************************
   logic [15:0] status_q, status_d, enable_q, control_q;
   pmev_pkg::pmev_power_e power_q, power_d;
   wire wr_any  = i_io_sel && i_io_wr;
   wire wr_stat = wr_any && (i_io_addr == pmev_pkg::PMEV_OFS_STATUS);
   wire wr_en   = wr_any && (i_io_addr == pmev_pkg::PMEV_OFS_ENABLE);
   wire wr_ctl  = wr_any && (i_io_addr == pmev_pkg::PMEV_OFS_CONTROL);
   wire sci_sel = control_q[pmev_pkg::PMEV_CTL_SCI];

   // ****************************************************************
   // power button override
   // ****************************************************************
   logic [15:0] ovr_cnt_q;
   wire ovr_arm  = pwr_good && btn_held                 // see [RULE3]
                && control_q[pmev_pkg::PMEV_CTL_OVR_EN]
                && (power_q == pmev_pkg::PMEV_RUN);
   wire ovr_fire = ovr_arm && slow_tick_q               // see [RULE1]
                && (ovr_cnt_q == 16'(OVR_TICKS));
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) ovr_cnt_q <= '0;
      else if (!ovr_arm || ovr_fire) ovr_cnt_q <= '0;   // see [RULE3]
      else if (slow_tick_q) ovr_cnt_q <= ovr_cnt_q + 16'h1;
   end

   wire resume_pend = status_q[pmev_pkg::PMEV_BIT_ALARM]
                   || status_q[pmev_pkg::PMEV_BIT_LID]
                   || status_q[pmev_pkg::PMEV_BIT_GPI];
   always_comb begin
      power_d = power_q;
      unique case (power_q)
         pmev_pkg::PMEV_RUN:
            if (ovr_fire) power_d = pmev_pkg::PMEV_SOFT_OFF; // see [RULE1]
         pmev_pkg::PMEV_SOFT_OFF:
            if (resume_pend) power_d = pmev_pkg::PMEV_RUN;   // see [RULE2]
      endcase
   end

   // ****************************************************************
   // status flags: hardware set beats a write-one clear
   // ****************************************************************
   logic [15:0] set_v, clr_v;
   always_comb begin
      set_v = '0;
      set_v[pmev_pkg::PMEV_BIT_TMROF] = i_pm_timer_overflow;
      set_v[pmev_pkg::PMEV_BIT_RLS]   = i_firmware_release;
      set_v[pmev_pkg::PMEV_BIT_BTN]   = btn_press && pwr_good;
      set_v[pmev_pkg::PMEV_BIT_ALARM] = i_rtc_irq8             // see [RULE5]
                                     && enable_q[pmev_pkg::PMEV_BIT_ALARM];
      set_v[pmev_pkg::PMEV_BIT_OVR]   = ovr_fire;              // see [RULE4]
      set_v[pmev_pkg::PMEV_BIT_LID]   = lid_change;
      set_v[pmev_pkg::PMEV_BIT_THERM] = therm_fall;
      set_v[pmev_pkg::PMEV_BIT_GPI]   = gpi_fall;
      clr_v = wr_stat ? i_io_wdata : 16'h0000;                 // see [RULE4]
      // override clears the press flag; the press itself is long past
      clr_v[pmev_pkg::PMEV_BIT_BTN] = clr_v[pmev_pkg::PMEV_BIT_BTN]
                                   || ovr_fire;                // see [RULE1]
      status_d = ((status_q & ~clr_v) | set_v) & pmev_pkg::PMEV_STATUS_MASK;
      if (ovr_fire) status_d[pmev_pkg::PMEV_BIT_BTN] = 1'b0;
   end

   // ****************************************************************
   // sci / smi routing
   // ****************************************************************
   wire [15:0] active = status_q & enable_q;
   wire routed = active[pmev_pkg::PMEV_BIT_BTN]
              || active[pmev_pkg::PMEV_BIT_LID]
              || active[pmev_pkg::PMEV_BIT_THERM]
              || active[pmev_pkg::PMEV_BIT_GPI];
   wire fixed_sci = active[pmev_pkg::PMEV_BIT_RLS]          // see [RULE9]
                 || active[pmev_pkg::PMEV_BIT_TMROF];
   wire sci_d = (sci_sel && routed) || fixed_sci;           // see [RULE7]
   wire smi_d = !sci_sel && routed;                         // see [RULE8]

   // ****************************************************************
   // thermal throttle and burst timers
   // ****************************************************************
   logic [15:0] therm_cnt_q;
   logic        throttle_q, full_q, stop_n_q;
   wire therm_fire = therm_held && slow_tick_q && !throttle_q
                  && (therm_cnt_q == 16'(THERM_TICKS));     // see [RULE10]
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         therm_cnt_q <= '0;
         throttle_q  <= 1'b0;
      end else begin
         if (!therm_held) therm_cnt_q <= '0;
         else if (slow_tick_q && !throttle_q)
            therm_cnt_q <= therm_cnt_q + 16'h1;
         if (!therm_held) throttle_q <= 1'b0;               // see [RULE11]
         else if (therm_fire) throttle_q <= 1'b1;           // see [RULE10]
      end
   end

   localparam int BW = pmev_pkg::PMEV_BURST_W;
   pmev_burst_if #(.W(BW)) bif[2] ();
   wire [1:0] burst_evt = {
      i_slow_burst_event && control_q[pmev_pkg::PMEV_CTL_SLOW_EN],
      i_fast_burst_event && control_q[pmev_pkg::PMEV_CTL_FAST_EN]};
   localparam logic [BW-1:0] RELOAD [2] = '{
      BW'(pmev_pkg::PMEV_FAST_BURST_TICKS),
      BW'(pmev_pkg::PMEV_SLOW_BURST_TICKS)};
   logic [1:0] b_busy, b_exp;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_burst           // see [RULE14]
         assign bif[gi].load   = burst_evt[gi];             // see [RULE12]
         assign bif[gi].reload = RELOAD[gi];
         assign bif[gi].tick   = slow_tick_q;
         assign b_busy[gi]     = bif[gi].busy;
         assign b_exp[gi]      = bif[gi].expire;
         pmev_burst_timer u_timer (
            .i_clock  (i_clock),
            .i_arst_n (i_arst_n),
            .bus      (bif[gi])
         );
      end
   endgenerate
   // disabling burst events mid-burst leaves the clock controlled for
   // good once the count runs out; software must not do it (see [RULE15])
   wire full_d = (|burst_evt)
              || (full_q && !((|b_exp) && !(|b_busy)));     // see [RULE13]
   wire stop_d = throttle_q ? phase_q                       // see [RULE10]
               : !(control_q[pmev_pkg::PMEV_CTL_CLKCTL] && !full_q);

   // ****************************************************************
   // state and read port
   // ****************************************************************
   wire [15:0] rd_mux =
      (i_io_addr == pmev_pkg::PMEV_OFS_STATUS)  ? status_q  :
      (i_io_addr == pmev_pkg::PMEV_OFS_ENABLE)  ? enable_q  :
      (i_io_addr == pmev_pkg::PMEV_OFS_CONTROL) ? control_q : 16'h0000;
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         status_q   <= pmev_pkg::PMEV_RST_STATUS;
         enable_q   <= pmev_pkg::PMEV_RST_ENABLE;
         control_q  <= pmev_pkg::PMEV_RST_CONTROL;
         power_q    <= pmev_pkg::PMEV_RUN;
         full_q     <= 1'b0;
         stop_n_q   <= 1'b1;
         o_sci      <= 1'b0;
         o_smi      <= 1'b0;
         o_io_rdata <= 16'h0000;
      end else begin
         status_q <= status_d;
         if (wr_en)                                         // see [RULE6]
            enable_q <= i_io_wdata & pmev_pkg::PMEV_ENABLE_MASK;
         if (wr_ctl)
            control_q <= i_io_wdata & pmev_pkg::PMEV_CONTROL_MASK;
         power_q  <= power_d;
         full_q   <= full_d;
         stop_n_q <= stop_d;                                // see [RULE11]
         o_sci    <= sci_d;
         o_smi    <= smi_d;
         if (i_io_sel && i_io_rd) o_io_rdata <= rd_mux;
      end
   end
   assign o_soft_off             = (power_q == pmev_pkg::PMEV_SOFT_OFF);
   assign o_clock_stop_request_n = stop_n_q;
endmodule : pmev_top

// ---- test/pmev_host_model.sv ----
// pmev_host_model: host side, counts sci and smi requests.
// assumes level interrupts synchronous to the block clock.
`timescale 1ns/1ps
module pmev_host_model (
   input  wire logic       i_clock,   // clock
   input  wire logic       i_arst_n,  // reset, low
   input  wire logic       i_sci,     // sci level
   input  wire logic       i_smi,     // smi level
   output logic      [7:0] o_sci_cnt, // sci requests
   output logic      [7:0] o_smi_cnt  // smi requests
);
   logic [1:0] lvl_q;
   // a level counts once per rise, as the host takes it on entry
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         lvl_q     <= 2'b00;
         o_sci_cnt <= 8'h00;
         o_smi_cnt <= 8'h00;
      end else begin
         lvl_q     <= {i_sci, i_smi};
         o_sci_cnt <= o_sci_cnt + 8'(i_sci & ~lvl_q[1]);
         o_smi_cnt <= o_smi_cnt + 8'(i_smi & ~lvl_q[0]);
      end
   end
endmodule : pmev_host_model

// ---- test/pmev_properties.sv ----
// pmev_properties: port level checks bound onto pmev_top.
// assumes word writes; shadows only the control word.
`timescale 1ns/1ps
module pmev_chk #(
   parameter int unsigned SLOW_DIV    = 4,
   parameter int unsigned OVR_TICKS   = 3,
   parameter int unsigned THERM_TICKS = 3
) (
   input wire logic        i_clock,               // clock
   input wire logic        i_arst_n,              // reset, low
   input wire logic        i_io_sel,              // select
   input wire logic        i_io_wr,               // write
   input wire logic        i_io_rd,               // read
   input wire logic [2:0]  i_io_addr,             // offset
   input wire logic [15:0] i_io_wdata,            // write data
   input wire logic [15:0] o_io_rdata,            // read data
   input wire logic        i_power_button_n,      // button
   input wire logic        i_power_good,          // power good
   input wire logic        i_thermal_alert_n,     // thermal
   input wire logic        i_fast_burst_event,    // fast burst
   input wire logic        o_smi,                 // smi
   input wire logic        o_soft_off,            // soft off
   input wire logic        o_clock_stop_request_n // clock stop
);
   // ****************
   // control shadow
   // ****************
   logic [4:0] ctl_q;
   logic [4:0] ctl_d;
   wire        ctl_wr = i_io_sel & i_io_wr & (i_io_addr == 3'h4);
   assign ctl_d = ctl_wr ? i_io_wdata[4:0] : ctl_q;
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) ctl_q <= 5'h00;
      else ctl_q <= ctl_d;
   end
   // ****************
   // properties
   // ****************
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_arst_n);
   chk_reset_outputs: assert property ($rose(i_arst_n) |-> !o_soft_off
      && o_clock_stop_request_n && !o_smi && o_io_rdata == 16'h0000)
      else $error("outputs not at rest after reset");
   chk_unmapped_read: assert property (i_io_sel && i_io_rd &&
      (i_io_addr[0] || i_io_addr[2:1] == 2'h3) |=> o_io_rdata == 16'h0000)
      else $error("unmapped read not zero");
   chk_rdata_holds: assert property (!(i_io_sel && i_io_rd)
      |=> $stable(o_io_rdata)) else $error("read data moved");
   chk_no_power_good: assert property (!i_power_good [*8]
      |=> !$rose(o_soft_off)) else $error("override without power good");
   chk_override_held: assert property ($rose(o_soft_off) |->
      !$past(i_power_button_n, 4) && !$past(i_power_button_n, 12))
      else $error("soft off without held button");
   chk_override_gated: assert property ($rose(o_soft_off) |->
      $past(ctl_q[1])) else $error("soft off with override off");
   chk_smi_route: assert property (o_smi |-> !$past(ctl_q[0]))
      else $error("smi while routed to sci");
   chk_burst_full: assert property (
      i_fast_burst_event && ctl_q[2] && i_thermal_alert_n
      |-> ##3 o_clock_stop_request_n) else $error("burst gave no full clock");
   chk_burst_expiry: assert property (
      $rose(o_clock_stop_request_n) && ctl_q[4] && !ctl_q[3]
      && i_thermal_alert_n |-> ##[1:40] !o_clock_stop_request_n)
      else $error("burst never ended");
endmodule : pmev_chk

bind pmev_top pmev_chk #(
   .SLOW_DIV(SLOW_DIV), .OVR_TICKS(OVR_TICKS), .THERM_TICKS(THERM_TICKS)
) chk_u (
   .i_clock(i_clock), .i_arst_n(i_arst_n), .i_io_sel(i_io_sel),
   .i_io_wr(i_io_wr), .i_io_rd(i_io_rd), .i_io_addr(i_io_addr),
   .i_io_wdata(i_io_wdata), .o_io_rdata(o_io_rdata),
   .i_power_button_n(i_power_button_n), .i_power_good(i_power_good),
   .i_thermal_alert_n(i_thermal_alert_n), .o_smi(o_smi),
   .i_fast_burst_event(i_fast_burst_event), .o_soft_off(o_soft_off),
   .o_clock_stop_request_n(o_clock_stop_request_n)
);

// ---- test/tb_pmev_top.sv ----
// tb_pmev_top: register, routing, override and clock tests of pmev_top.
// assumes short slow tick parameters so the run stays brief.
`timescale 1ns/1ps
module tb_pmev_top;
   logic        clock, arst_n, sel, wr, rd, pg, btn_n, lid_input, therm_n, gpi_n;
   logic [2:0]  addr;
   logic [15:0] wdata, rdata;
   logic [4:0]  ev;
   logic        sci, smi, off, stop_n;
   logic [7:0]  sci_cnt, smi_cnt;
   int          miscompares, samples_checked, n;
   int          src_bit[4] = '{8, 12, 13, 14};
   pmev_top #(.SLOW_DIV(4), .OVR_TICKS(3), .THERM_TICKS(3)) dut_u (
      .i_clock(clock), .i_arst_n(arst_n), .i_io_sel(sel), .i_io_wr(wr),
      .i_io_rd(rd), .i_io_addr(addr), .i_io_wdata(wdata),
      .o_io_rdata(rdata), .i_power_button_n(btn_n), .i_lid_input(lid_input),
      .i_thermal_alert_n(therm_n), .i_general_input_one_n(gpi_n),
      .i_power_good(pg), .i_rtc_irq8(ev[0]), .i_firmware_release(ev[1]),
      .i_pm_timer_overflow(ev[2]), .i_fast_burst_event(ev[3]),
      .i_slow_burst_event(ev[4]), .o_sci(sci), .o_smi(smi),
      .o_soft_off(off), .o_clock_stop_request_n(stop_n));
   pmev_host_model host_u (.i_clock(clock), .i_arst_n(arst_n),
      .i_sci(sci), .i_smi(smi), .o_sci_cnt(sci_cnt), .o_smi_cnt(smi_cnt));
   // ****************
   // access tasks
   // ****************
   task automatic check(input string nm, input logic [15:0] e, g);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask : check
   task automatic cyc(input int k);
      repeat (k) @(posedge clock);
   endtask : cyc
   task automatic wreg(input logic [2:0] a, input logic [15:0] d);
      @(posedge clock);
      {sel, wr, addr, wdata} <= {2'b11, a, d};
      @(posedge clock);
      {sel, wr} <= 2'b00;
   endtask : wreg
   task automatic rreg(input logic [2:0] a, input logic [15:0] e);
      @(posedge clock);
      {sel, rd, addr} <= {2'b11, a};
      @(posedge clock);
      {sel, rd} <= 2'b00;
      #1 check("register", e, rdata);
   endtask : rreg
   task automatic pulse(input int b);
      @(posedge clock);
      ev <= 5'h01 << b;
      @(posedge clock);
      ev <= 5'h00;
   endtask : pulse
   task automatic pin(input int i, input logic act);
      @(posedge clock);
      case (i)
         0: btn_n <= !act;
         1: lid_input <= act;
         2: therm_n <= !act;
         default: gpi_n <= !act;
      endcase
   endtask : pin
   // control word is left alone while a burst runs
   task automatic burst(input int b, input logic [15:0] c, input int lo, hi);
      wreg(3'h4, c);
      cyc(3);
      check("stop", 16'h0000, 16'(stop_n));
      pulse(b);
      cyc(3);
      check("stop", 16'h0001, 16'(stop_n));
      n = 0;
      while (stop_n === 1'b1 && n < 400) begin
         @(posedge clock);
         n++;
      end
      check("burst length", 16'h0001, 16'(n >= lo && n <= hi));
   endtask : burst
   task automatic complete_run;
      $display("checked %0d mismatched %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : complete_run
   // ****************
   // sequence
   // ****************
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   initial begin
      #100000 miscompares++;
      complete_run();
   end
   initial begin
      {arst_n, sel, wr, rd, addr, wdata, ev, lid_input} = '0;
      {pg, btn_n, therm_n, gpi_n} = 4'hf;
      repeat (16) @(posedge clock);
      arst_n <= 1'b1;
      cyc(4);
      for (int a = 0; a < 6; a += 2) rreg(3'(a), 16'h0000);
      wreg(3'h2, 16'hffff);
      wreg(3'h6, 16'hffff);
      rreg(3'h6, 16'h0000);
      rreg(3'h2, 16'h7521);
      wreg(3'h4, 16'hffff);
      rreg(3'h4, 16'h001f);
      wreg(3'h2, 16'h0000);
      wreg(3'h4, 16'h0000);
      pulse(0);
      rreg(3'h0, 16'h0000);
      wreg(3'h2, 16'h0400);
      pulse(0);
      rreg(3'h0, 16'h0400);
      for (int r = 1; r >= 0; r--) begin
         wreg(3'h4, 16'(r));
         for (int i = 0; i < 4; i++) begin
            wreg(3'h2, 16'h0001 << src_bit[i]);
            pin(i, 1'b1);
            cyc(6);
            check("sci", 16'(r), 16'(sci));
            check("smi", 16'(1 - r), 16'(smi));
            pin(i, 1'b0);
            cyc(6);
            wreg(3'h0, 16'hffff);
         end
      end
      for (int k = 0; k < 2; k++) begin
         wreg(3'h2, 16'h0000);
         pulse(k + 1);
         cyc(3);
         check("sci", 16'h0000, 16'(sci));
         wreg(3'h2, (k == 1) ? 16'h0001 : 16'h0020);
         cyc(3);
         check("sci", 16'h0001, 16'(sci));
         wreg(3'h0, 16'hffff);
      end
      wreg(3'h4, 16'h0002);
      pg <= 1'b0;
      pin(0, 1'b1);
      cyc(40);
      check("soft off", 16'h0000, 16'(off));
      pin(0, 1'b0);
      pg <= 1'b1;
      cyc(6);
      wreg(3'h0, 16'hffff);
      pin(0, 1'b1);
      cyc(40);
      check("soft off", 16'h0001, 16'(off));
      pin(0, 1'b0);
      cyc(4);
      rreg(3'h0, 16'h0800);
      wreg(3'h0, 16'h0000);
      rreg(3'h0, 16'h0800);
      wreg(3'h0, 16'h0800);
      rreg(3'h0, 16'h0000);
      pin(1, 1'b1);
      cyc(8);
      check("soft off", 16'h0000, 16'(off));
      // lid flag still pending: soft off from the override must wake straight back to run
      wreg(3'h4, 16'h0002);
      pin(0, 1'b1);
      cyc(24);
      pin(0, 1'b0);
      cyc(20);
      check("soft off", 16'h0000, 16'(off));
      rreg(3'h0, 16'h1800);
      burst(3, 16'h0014, 4, 24);
      burst(4, 16'h0018, 100, 140);
      wreg(3'h4, 16'h0010);
      pin(2, 1'b1);
      cyc(30);
      n = 0;
      repeat (20) begin
         @(posedge clock);
         n += int'(stop_n);
      end
      check("throttle", 16'h0001, 16'(n > 0 && n < 20));
      pin(2, 1'b0);
      cyc(8);
      check("stop", 16'h0000, 16'(stop_n));
      check("smi count", 16'h0004, 16'(smi_cnt));
      check("sci count", 16'h0006, 16'(sci_cnt));
      complete_run();
   end
endmodule : tb_pmev_top
